// [design/ala_params.svh]
`ifndef ALA_PARAMS_SVH
`define ALA_PARAMS_SVH
`define ALA_ADDR_CTRL 8'h00
`define ALA_ADDR_TYPE 8'h04
`define ALA_ADDR_BLOCK 8'h08
`define ALA_ADDR_STATUS 8'h0c
`define ALA_ADDR_ACKED 8'h10
`define ALA_ADDR_UNACK 8'h14
`define ALA_ADDR_OUTS 8'h18
`define ALA_CTRL_GACK 0
`define ALA_CTRL_RESTORE 1
`define ALA_NUM_ALARMS 4
`define ALA_FLASH_HALF_NS 250000000
`define ALA_CLK_NS 100
`endif

// [design/ala_pkg.sv]
package ala_pkg;
  typedef enum logic [1:0] {
    ALA_TYPE_NONE = 2'h0,
    ALA_TYPE_AUTO = 2'h1,
    ALA_TYPE_MANUAL = 2'h2,
    ALA_TYPE_EVENT = 2'h3
  } ala_type_t;
  typedef enum logic [1:0] {
    ALA_ST_IDLE = 2'h0,
    ALA_ST_ACTIVE = 2'h1,
    ALA_ST_ACKED = 2'h2,
    ALA_ST_UNACK = 2'h3
  } ala_state_t;
endpackage : ala_pkg

// [design/ala_nv_store.sv]
`timescale 1ns/10ps
`default_nettype none
// ********************************************************************
// Retained alarm state, modelled as a small register memory
// ********************************************************************
module ala_nv_store #(
  parameter int N = 4
) (
  input wire logic clock,
  input wire logic we,
  input wire logic [2*N-1:0] wdata,
  output logic [2*N-1:0] rdata
);
  logic [2*N-1:0] mem;
  // No reset: contents must survive the device's own reset
  always_ff @(posedge clock) begin
    if (we) begin
      mem <= wdata;
    end
    rdata <= mem;
  end
endmodule // ala_nv_store
`default_nettype wire

// [design/ala_channel.sv]
`timescale 1ns/10ps
`default_nettype none
// ********************************************************************
// One alarm channel: latching state machine
// ********************************************************************
module ala_channel (
  input wire logic clock,
  input wire logic srst,
  input wire logic cond,
  input wire logic ack_pulse,
  input wire logic [1:0] latch_type,
  input wire logic block_cfg,
  input wire logic restore,
  input wire logic [1:0] saved_state,
  output ala_pkg::ala_state_t state,
  output logic blocked,
  output logic output_on,
  output logic needs_attention,
  output logic is_active
);
  ala_pkg::ala_state_t next_state;
  logic next_blocked;
  logic is_none, is_auto, is_man, is_evt;
  ala_pkg::ala_state_t saved;

  assign is_none = latch_type == 2'(ala_pkg::ALA_TYPE_NONE);
  assign is_auto = latch_type == 2'(ala_pkg::ALA_TYPE_AUTO);
  assign is_man = latch_type == 2'(ala_pkg::ALA_TYPE_MANUAL);
  assign is_evt = latch_type == 2'(ala_pkg::ALA_TYPE_EVENT);
  assign saved = ala_pkg::ala_state_t'(saved_state);

  always_comb begin
    next_state = state;
    next_blocked = blocked;
    if (restore) begin
      next_blocked = 1'b0;
      unique case (saved)
        ala_pkg::ALA_ST_ACTIVE, ala_pkg::ALA_ST_ACKED: begin
          if (is_man) begin
            next_state = cond ? saved : ala_pkg::ALA_ST_UNACK;
          end else if (is_auto) begin
            if (block_cfg && saved == ala_pkg::ALA_ST_ACKED) begin
              next_state = ala_pkg::ALA_ST_IDLE;
              next_blocked = 1'b1;
            end else if (cond) begin
              next_state = saved;
            end else begin
              next_state = (saved == ala_pkg::ALA_ST_ACKED) ?
                ala_pkg::ALA_ST_IDLE : ala_pkg::ALA_ST_UNACK;
            end
          end else if (block_cfg) begin
            next_state = ala_pkg::ALA_ST_IDLE;
            next_blocked = 1'b1;
          end else begin
            next_state = cond ? saved : ala_pkg::ALA_ST_IDLE;
          end
        end
        ala_pkg::ALA_ST_UNACK: begin
          next_state = (is_auto || is_man) ? ala_pkg::ALA_ST_UNACK :
            ala_pkg::ALA_ST_IDLE;
        end
        ala_pkg::ALA_ST_IDLE: next_state = ala_pkg::ALA_ST_IDLE;
      endcase
    end else if (blocked) begin
      // Blocking lifts once the condition has gone away
      if (!cond) begin
        next_blocked = 1'b0;
      end
    end else begin
      unique case (state)
        ala_pkg::ALA_ST_IDLE: begin
          if (cond) begin
            next_state = ala_pkg::ALA_ST_ACTIVE;
          end
        end
        ala_pkg::ALA_ST_ACTIVE: begin
          if (is_evt || is_none) begin
            if (!cond) next_state = ala_pkg::ALA_ST_IDLE;
            else if (ack_pulse && is_none) next_state = ala_pkg::ALA_ST_ACKED;
          end else if (is_auto) begin
            if (ack_pulse) next_state = ala_pkg::ALA_ST_ACKED;
            else if (!cond) next_state = ala_pkg::ALA_ST_UNACK;
          end else begin
            if (!cond) next_state = ala_pkg::ALA_ST_UNACK;
          end
        end
        ala_pkg::ALA_ST_ACKED: begin
          if (!cond) next_state = ala_pkg::ALA_ST_IDLE;
        end
        ala_pkg::ALA_ST_UNACK: begin
          if (cond) next_state = ala_pkg::ALA_ST_ACTIVE;
          else if (ack_pulse) next_state = ala_pkg::ALA_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state <= ala_pkg::ALA_ST_IDLE;
      blocked <= 1'b0;
    end else begin
      state <= next_state;
      blocked <= next_blocked;
    end
  end

  assign is_active = state != ala_pkg::ALA_ST_IDLE;
  assign output_on = is_active;
  // Event alarms never show on the beacon or display
  assign needs_attention = !is_evt &&
    (state == ala_pkg::ALA_ST_ACTIVE || state == ala_pkg::ALA_ST_UNACK);

  property p_evt_no_latch;
    @(posedge clock) disable iff (srst)
      (is_evt && !restore && !blocked && state != ala_pkg::ALA_ST_IDLE && !cond)
      |=> state == ala_pkg::ALA_ST_IDLE;
  endproperty
  a_evt_no_latch: assert property (p_evt_no_latch) else $error("event alarm latched");

  property p_man_ack_ignored;
    @(posedge clock) disable iff (srst)
      (is_man && !restore && !blocked && state == ala_pkg::ALA_ST_ACTIVE && cond)
      |=> state == ala_pkg::ALA_ST_ACTIVE;
  endproperty
  a_man_ack_ignored: assert property (p_man_ack_ignored) else $error("manual ack not ignored");

  property p_man_stays;
    @(posedge clock) disable iff (srst)
      (is_man && !restore && state == ala_pkg::ALA_ST_UNACK && !cond && !ack_pulse)
      |=> state == ala_pkg::ALA_ST_UNACK;
  endproperty
  a_man_stays: assert property (p_man_stays) else $error("manual alarm cleared without ack");

  property p_auto_ack;
    @(posedge clock) disable iff (srst)
      (is_auto && !restore && !blocked && state == ala_pkg::ALA_ST_ACTIVE && ack_pulse)
      |=> state == ala_pkg::ALA_ST_ACKED;
  endproperty
  a_auto_ack: assert property (p_auto_ack) else $error("auto ack not taken");

  property p_man_no_block;
    @(posedge clock) disable iff (srst)
      (restore && is_man) |=> !blocked;
  endproperty
  a_man_no_block: assert property (p_man_no_block) else $error("manual alarm blocked");
endmodule // ala_channel
`default_nettype wire

// [design/ala_top.sv]
// The implementer's own choices: the register offsets and the Avalon-MM slave port.
`include "ala_params.svh"
`timescale 1ns/10ps
`default_nettype none
// ********************************************************************
// Alarm latch and acknowledge block
// ********************************************************************
module ala_top #(
  parameter int N = `ALA_NUM_ALARMS,
  parameter int FLASH_HALF_CYCLES = `ALA_FLASH_HALF_NS / `ALA_CLK_NS
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [N-1:0] alarm_cond,
  input wire logic [N-1:0] ack_in,
  input wire logic global_ack_in,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [N-1:0] alarm_output,
  output logic [N-1:0] output_beacon,
  output logic alarm_beacon,
  output logic top_row_red,
  output logic scroll_message
);
  // ******************************************************************
  // Input synchronisers and acknowledge edge detection
  // ******************************************************************
  logic [N:0] ack_s1, ack_s2, ack_s3;
  logic [N-1:0] cond_s1, cond_s2;
  logic [N-1:0] ack_pulse;
  logic gack_reg, gack_reg_d;
  wire [N:0] ack_raw = {global_ack_in, ack_in};
  wire [N:0] ack_rise = ack_s2 & ~ack_s3;
  wire gack_pulse = ack_rise[N] || (gack_reg && !gack_reg_d);
  assign ack_pulse = ack_rise[N-1:0] | {N{gack_pulse}};

  always_ff @(posedge clock) begin
    if (srst) begin
      ack_s1 <= '0;
      ack_s2 <= '0;
      ack_s3 <= '0;
      cond_s1 <= '0;
      cond_s2 <= '0;
      gack_reg_d <= 1'b0;
    end else begin
      ack_s1 <= ack_raw;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
      cond_s1 <= alarm_cond;
      cond_s2 <= cond_s1;
      gack_reg_d <= gack_reg;
    end
  end

  // ******************************************************************
  // Registers
  // ******************************************************************
  logic [2*N-1:0] type_reg;
  logic [N-1:0] block_reg;
  logic restore_req, restore_d;
  logic [2*N-1:0] saved_states, live_states;
  logic [N-1:0] blocked, out_on, attn, active;
  logic nv_loaded;

  // Writes land only on the accepting edge, so a CTRL strobe fires once
  wire wr_go = avs_write && !avs_waitrequest;
  wire wr_ctrl = wr_go && avs_address == `ALA_ADDR_CTRL && avs_byteenable[0];
  wire wr_type = wr_go && avs_address == `ALA_ADDR_TYPE && avs_byteenable[0];
  wire wr_block = wr_go && avs_address == `ALA_ADDR_BLOCK && avs_byteenable[0];

  always_ff @(posedge clock) begin
    if (srst) begin
      type_reg <= '0;
      block_reg <= '0;
      gack_reg <= 1'b0;
      restore_req <= 1'b0;
    end else begin
      if (wr_type) type_reg <= avs_writedata[2*N-1:0];
      if (wr_block) block_reg <= avs_writedata[N-1:0];
      gack_reg <= wr_ctrl && avs_writedata[`ALA_CTRL_GACK];
      restore_req <= wr_ctrl && avs_writedata[`ALA_CTRL_RESTORE];
    end
  end

  // Readback of retained state takes a cycle, so restore is applied one cycle late
  always_ff @(posedge clock) begin
    if (srst) begin
      restore_d <= 1'b0;
      nv_loaded <= 1'b0;
    end else begin
      restore_d <= restore_req;
      nv_loaded <= 1'b1;
    end
  end

  // Wait states: one cycle for every access keeps the readback registered
  logic ack_done;
  always_ff @(posedge clock) begin
    if (srst) begin
      ack_done <= 1'b0;
    end else begin
      ack_done <= (avs_read || avs_write) && !ack_done;
    end
  end
  assign avs_waitrequest = (avs_read || avs_write) && !ack_done;

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (avs_address)
      `ALA_ADDR_TYPE: rd_mux[2*N-1:0] = type_reg;
      `ALA_ADDR_BLOCK: rd_mux[N-1:0] = block_reg;
      `ALA_ADDR_STATUS: rd_mux[N-1:0] = active;
      `ALA_ADDR_ACKED: rd_mux[2*N-1:0] = live_states;
      `ALA_ADDR_UNACK: rd_mux[N-1:0] = attn;
      `ALA_ADDR_OUTS: rd_mux[N-1:0] = blocked;
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && !ack_done) begin
      avs_readdata <= rd_mux;
    end
  end

  // ******************************************************************
  // Channels and retained state
  // ******************************************************************
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      ala_pkg::ala_state_t st;
      ala_channel u_ch (
        .clock(clock),
        .srst(srst),
        .cond(cond_s2[g]),
        .ack_pulse(ack_pulse[g]),
        .latch_type(type_reg[2*g+1:2*g]),
        .block_cfg(block_reg[g]),
        .restore(restore_d),
        .saved_state(saved_states[2*g+1:2*g]),
        .state(st),
        .blocked(blocked[g]),
        .output_on(out_on[g]),
        .needs_attention(attn[g]),
        .is_active(active[g])
      );
      assign live_states[2*g+1:2*g] = st;
    end
  endgenerate

  // Stored continuously, frozen while a restore is being taken
  ala_nv_store #(.N(N)) u_nv (
    .clock(clock),
    .we(nv_loaded && !restore_req && !restore_d),
    .wdata(live_states),
    .rdata(saved_states)
  );

  // ******************************************************************
  // Indication
  // ******************************************************************
  logic [$clog2(FLASH_HALF_CYCLES+1)-1:0] flash_cnt;
  logic flash;
  always_ff @(posedge clock) begin
    if (srst) begin
      flash_cnt <= '0;
      flash <= 1'b0;
    end else if (flash_cnt == $bits(flash_cnt)'(FLASH_HALF_CYCLES - 1)) begin
      flash_cnt <= '0;
      flash <= !flash;
    end else begin
      flash_cnt <= flash_cnt + 1'b1;
    end
  end

  // Event alarms drive their output but stay off the display and beacon
  function automatic logic evt_type(input logic [1:0] t);
    return t == 2'(ala_pkg::ALA_TYPE_EVENT);
  endfunction

  wire any_attn = |attn;
  logic [N-1:0] shown, evt_mask;
  for (g = 0; g < N; g++) begin : g_show
    assign evt_mask[g] = evt_type(type_reg[2*g+1:2*g]);
    assign shown[g] = active[g] && !evt_mask[g];
  end
  wire any_shown = |shown;

  always_ff @(posedge clock) begin
    if (srst) begin
      alarm_output <= '1;
      output_beacon <= '0;
      alarm_beacon <= 1'b0;
      top_row_red <= 1'b0;
      scroll_message <= 1'b0;
    end else begin
      alarm_output <= ~out_on;
      output_beacon <= out_on;
      alarm_beacon <= any_attn ? flash : any_shown;
      top_row_red <= any_attn;
      scroll_message <= any_shown;
    end
  end

  // ******************************************************************
  // Checks
  // ******************************************************************
  property p_beacon_off;
    @(posedge clock) disable iff (srst)
      (!any_shown && !any_attn) |=> !alarm_beacon;
  endproperty
  a_beacon_off: assert property (p_beacon_off) else $error("beacon lit with no alarm");

  property p_out_deenergised;
    @(posedge clock) disable iff (srst)
      out_on[0] |=> !alarm_output[0] && output_beacon[0];
  endproperty
  a_out_deenergised: assert property (p_out_deenergised) else $error("output not driven");

  property p_ack_once;
    @(posedge clock) disable iff (srst)
      ack_s2[0] && ack_s3[0] && !gack_pulse |-> !ack_pulse[0];
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("held ack repeated");

  property p_gack_all;
    @(posedge clock) disable iff (srst)
      gack_pulse |-> &ack_pulse;
  endproperty
  a_gack_all: assert property (p_gack_all) else $error("global ack missed one");

  property p_red_follows;
    @(posedge clock) disable iff (srst)
      any_attn |=> top_row_red;
  endproperty
  a_red_follows: assert property (p_red_follows) else $error("top row not red");

  property p_red_clears;
    @(posedge clock) disable iff (srst)
      !any_attn |=> !top_row_red;
  endproperty
  a_red_clears: assert property (p_red_clears) else $error("top row red with nothing due");

  property p_scroll_follows;
    @(posedge clock) disable iff (srst)
      any_shown |=> scroll_message;
  endproperty
  a_scroll_follows: assert property (p_scroll_follows) else $error("message not shown");

  property p_steady;
    @(posedge clock) disable iff (srst)
      (!any_attn && any_shown) |=> alarm_beacon;
  endproperty
  a_steady: assert property (p_steady) else $error("acked alarm beacon not steady");

  property p_evt_silent;
    @(posedge clock) disable iff (srst)
      &(evt_mask | ~active) |=> !scroll_message && !top_row_red && !alarm_beacon;
  endproperty
  a_evt_silent: assert property (p_evt_silent) else $error("event alarm indicated");

  property p_out_pair;
    @(posedge clock) disable iff (srst)
      output_beacon == ~alarm_output;
  endproperty
  a_out_pair: assert property (p_out_pair) else $error("output and its beacon differ");

  property p_ack_single;
    @(posedge clock) disable iff (srst)
      ack_rise[0] |=> !ack_rise[0];
  endproperty
  a_ack_single: assert property (p_ack_single) else $error("ack edge lasted two cycles");

  property p_one_wait;
    @(posedge clock) disable iff (srst)
      avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("more than one wait state");

  property p_unmapped_zero;
    @(posedge clock) disable iff (srst)
      (avs_read && !ack_done && avs_address > `ALA_ADDR_OUTS) |=> avs_readdata == 32'h0;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

  property p_wr_once;
    @(posedge clock) disable iff (srst)
      restore_req |=> !restore_req;
  endproperty
  a_wr_once: assert property (p_wr_once) else $error("restore strobe repeated");

  c_attn: cover property (@(posedge clock) disable iff (srst) any_attn ##[1:20] !any_attn);
  c_restore: cover property (@(posedge clock) disable iff (srst) restore_d);
  c_blocked: cover property (@(posedge clock) disable iff (srst) |blocked);
  c_gack: cover property (@(posedge clock) disable iff (srst) gack_pulse);
  c_evt_out: cover property (@(posedge clock) disable iff (srst) active[0] && evt_mask[0]);
endmodule // ala_top
`default_nettype wire

// [sim/ala_src.sv]
`timescale 1ns/10ps
`default_nettype none
// ********************************************************************
// Condition detectors and acknowledge sources facing the block
// ********************************************************************
module ala_src #(
  parameter int N = 4
) (
  input wire logic clock,
  input wire logic [N-1:0] cond_req,
  input wire logic [N-1:0] ack_req,
  input wire logic gack_req,
  output var logic [N-1:0] alarm_cond,
  output var logic [N-1:0] ack_in,
  output var logic global_ack_in
);
  // Quiet sources at power-up so no input starts unknown
  initial begin
    alarm_cond = '0;
    ack_in = '0;
    global_ack_in = 1'b0;
  end

  // Sources only move on a clock edge, like a debounced key or input stage
  always @(posedge clock) begin
    alarm_cond <= cond_req;
    ack_in <= ack_req;
    global_ack_in <= gack_req;
  end
endmodule // ala_src
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int N = 4;
  typedef struct packed {
    logic [1:0] typ;
    logic cond;
    logic ack;
    logic [1:0] st;
    logic out;
    logic scr;
  } ala_row_t;
  logic clock, srst, gack_req, avs_read, avs_write, avs_waitrequest;
  logic alarm_beacon, top_row_red, scroll_message, global_ack_in;
  logic [N-1:0] cond_req, ack_req, alarm_cond, ack_in, alarm_output, output_beacon;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [1:0] cur;
  int miscompares, checks, t;
  // Single alarm walked through manual, auto, event and none types
  ala_row_t rows [13] = '{8'ha7, 8'hb7, 8'h8f, 8'h90, 8'h67, 8'h7b, 8'h40,
                          8'he6, 8'hf6, 8'hc0, 8'h27, 8'h3b, 8'h00};

  ala_src #(.N(N)) src (.clock(clock), .cond_req(cond_req), .ack_req(ack_req),
    .gack_req(gack_req), .alarm_cond(alarm_cond), .ack_in(ack_in),
    .global_ack_in(global_ack_in));

  // Short flash period keeps the run brief
  ala_top #(.N(N), .FLASH_HALF_CYCLES(4)) dut (.clock(clock), .srst(srst),
    .alarm_cond(alarm_cond), .ack_in(ack_in), .global_ack_in(global_ack_in),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .alarm_output(alarm_output),
    .output_beacon(output_beacon), .alarm_beacon(alarm_beacon),
    .top_row_red(top_row_red), .scroll_message(scroll_message));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic print_verdict;
    if (miscompares == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) chk("waitrequest", 32'h0, 32'h1);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    tick(1);
  endtask

  task automatic pulse(input int i);
    ack_req[i] <= 1'b1;
    tick(1);
    ack_req[i] <= 1'b0;
    tick(8);
  endtask

  task automatic toggles(output int c);
    logic p;
    c = 0;
    p = alarm_beacon;
    repeat (20) begin
      @(posedge clock);
      if (alarm_beacon !== p) c++;
      p = alarm_beacon;
    end
  endtask

  task automatic rst;
    srst <= 1'b1;
    tick(16);
    srst <= 1'b0;
    tick(1);
  endtask

  initial begin
    srst = 1'b1;
    gack_req = 1'b0;
    cond_req = '0;
    ack_req = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    rst();
    chk("alarm_output", 32'hf, alarm_output);
    bus(1'b0, 8'h04, 32'h0, rd);
    chk("type", 32'h0, rd);
    cur = 2'h0;
    foreach (rows[i]) begin
      if (rows[i].typ !== cur) begin
        bus(1'b1, 8'h04, {30'h0, rows[i].typ}, rd);
        cur = rows[i].typ;
      end
      cond_req[0] <= rows[i].cond;
      tick(8);
      if (rows[i].ack) pulse(0);
      bus(1'b0, 8'h10, 32'h0, rd);
      chk("state0", rows[i].st, rd[1:0]);
      chk("beacon0", rows[i].out, output_beacon[0]);
      chk("output0", !rows[i].out, alarm_output[0]);
      chk("scroll", rows[i].scr, scroll_message);
    end
    // Mixed types on all alarms, one global acknowledge
    bus(1'b1, 8'h04, 32'h39, rd);
    cond_req <= 4'hf;
    tick(8);
    toggles(t);
    chk("flash", 32'h1, t >= 2);
    chk("red", 32'h1, top_row_red);
    gack_req <= 1'b1;
    tick(1);
    gack_req <= 1'b0;
    tick(8);
    bus(1'b0, 8'h10, 32'h0, rd);
    chk("gack", 32'h86, rd & 32'hcf);
    chk("event", 32'h1, output_beacon[2]);
    // Held acknowledge counts once only
    cond_req[1] <= 1'b0;
    tick(8);
    ack_req[1] <= 1'b1;
    tick(8);
    cond_req[1] <= 1'b1;
    tick(8);
    bus(1'b0, 8'h10, 32'h0, rd);
    chk("held", 32'h1, rd[3:2]);
    cond_req[1] <= 1'b0;
    tick(8);
    bus(1'b0, 8'h10, 32'h0, rd);
    chk("held_clear", 32'h3, rd[3:2]);
    ack_req[1] <= 1'b0;
    tick(8);
    pulse(1);
    toggles(t);
    chk("steady", 32'h0, t);
    chk("beacon", 32'h1, alarm_beacon);
    cond_req <= 4'h0;
    tick(8);
    chk("beacon", 32'h0, alarm_beacon);
    // Restore: acked auto blocks, manual never does
    bus(1'b1, 8'h04, 32'h9, rd);
    bus(1'b1, 8'h08, 32'h3, rd);
    cond_req <= 4'h3;
    tick(8);
    pulse(0);
    bus(1'b1, 8'h00, 32'h2, rd);
    tick(10);
    bus(1'b0, 8'h18, 32'h0, rd);
    chk("blocked", 32'h1, rd & 32'h3);
    bus(1'b0, 8'h10, 32'h0, rd);
    chk("manual", 32'h1, rd[3:2]);
    bus(1'b0, 8'hfc, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    // Restore without blocking: latched manual and present non-latching alarms
    bus(1'b1, 8'h08, 32'h0, rd);
    cond_req <= 4'h6;
    tick(8);
    cond_req <= 4'h4;
    tick(8);
    bus(1'b1, 8'h00, 32'h2, rd);
    tick(10);
    bus(1'b0, 8'h10, 32'h0, rd);
    chk("restore", 32'h1c, rd);
    bus(1'b1, 8'h00, 32'h1, rd);
    tick(2);
    bus(1'b0, 8'h10, 32'h0, rd);
    chk("ctrl_gack", 32'h20, rd);
    // Reset in mid-run with an acknowledged non-latching alarm still active
    cond_req <= 4'h0;
    rst();
    chk("alarm_output", 32'hf, alarm_output);
    bus(1'b0, 8'h04, 32'h0, rd);
    chk("type", 32'h0, rd);
    print_verdict();
  end

  // Whole run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    print_verdict();
  end
endmodule // tb
`default_nettype wire
